// File: rtl/sctr_pkg.sv
package sctr_pkg;

	// ----------------------------------------------------------------
	// clock and widths
	// ----------------------------------------------------------------
	localparam int CLK_PS = 50000;
	localparam int CNT_W = 12;
	localparam int BA_W = 2;
	localparam int ADDR_W = 11;
	localparam int ROW_W = 11;
	localparam int COL_W = 8;
	localparam int DQ_W = 32;
	localparam int AP_BIT = 10;
	typedef logic [CNT_W-1:0] sctr_cnt_t;

	// ----------------------------------------------------------------
	// memory timing figures, slowest speed grade
	// ----------------------------------------------------------------
	localparam int T_RC_PS = 70000;
	localparam int T_RAS_MIN_PS = 42000;
	localparam int T_RAS_MAX_NS = 120000;
	localparam int T_RP_PS = 20000;
	localparam int T_RCD_PS = 20000;
	localparam int T_RRD_PS = 14000;
	localparam int T_XSR_PS = 77000;
	localparam int T_CKA_EXTRA_PS = 3000;
	localparam int T_PWR_US = 100;
	localparam int REF_PERIOD_MS = 64;
	localparam int REF_PERIOD_HOT_MS = 16;
	localparam int REF_COUNT = 4096;
	localparam int DPL_CYC = 2;
	localparam int MRD_CYC = 2;
	localparam int SRX_CLOCKS = 2;
	localparam int CAS_LAT = 2;
	localparam int WAKE_REFS = 2;

	function automatic int cmax(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : cmax

	// least times round up, never below one cycle
	function automatic int ceil_cyc(input int ps);
		return cmax((ps + CLK_PS - 1) / CLK_PS, 1);
	endfunction : ceil_cyc

	// ----------------------------------------------------------------
	// derived cycle counts
	// ----------------------------------------------------------------
	localparam int RC_CYC = ceil_cyc(T_RC_PS);
	localparam int RAS_MIN_CYC = ceil_cyc(T_RAS_MIN_PS);
	localparam int RAS_MAX_CYC = T_RAS_MAX_NS * 1000 / CLK_PS;
	localparam int RP_CYC = ceil_cyc(T_RP_PS);
	localparam int RCD_CYC = ceil_cyc(T_RCD_PS);
	localparam int RRD_CYC = ceil_cyc(T_RRD_PS);
	localparam int XSR_CYC = ceil_cyc(T_XSR_PS);
	localparam int CKA_CYC = ceil_cyc(CLK_PS + T_CKA_EXTRA_PS);
	localparam int PWR_CYC = ceil_cyc(T_PWR_US * 1000000);
	localparam int REF_INT_CYC = (REF_PERIOD_MS * 1000000 / REF_COUNT) * 1000 / CLK_PS;
	localparam int REF_INT_HOT_CYC = (REF_PERIOD_HOT_MS * 1000000 / REF_COUNT) * 1000 / CLK_PS;
	localparam int PRE_WAIT = cmax(RP_CYC, cmax(RC_CYC, RRD_CYC));
	localparam int RD_PRE_WAIT = cmax(RAS_MIN_CYC, RCD_CYC + 1) - RCD_CYC;
	localparam int WR_PRE_WAIT = cmax(DPL_CYC, RD_PRE_WAIT);
	localparam int SRX_WAIT = cmax(XSR_CYC, cmax(CKA_CYC, SRX_CLOCKS));
	localparam int RD_CAP = CAS_LAT + 1;

	// ----------------------------------------------------------------
	// commands {cs_n, ras_n, cas_n, we_n} and mode word
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_MRS = 4'h0;
	// burst length 1, sequential, cas latency 2
	localparam logic [ADDR_W-1:0] MODE_WORD = 11'h020;

endpackage : sctr_pkg

// File: rtl/sctr_tick.sv
`timescale 1ns/10ps
module sctr_tick (
	input wire logic clock_in, // controller clock
	input wire logic srst_in, // sync reset
	input wire logic ce_in, // clock enable
	input wire logic restart_in, // reload the period now
	input wire sctr_pkg::sctr_cnt_t period_in, // period in cycles
	output logic tick_out // one-cycle pulse per period
);

	sctr_pkg::sctr_cnt_t count_q;

	// ----------------------------------------------------------------
	// periodic down-counter
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			count_q <= '0;
			tick_out <= 1'b0;
		end else if (ce_in) begin
			tick_out <= (count_q == '0) && !restart_in;
			if (restart_in || count_q == '0) begin
				count_q <= period_in - sctr_pkg::sctr_cnt_t'(1);
			end else begin
				count_q <= count_q - sctr_pkg::sctr_cnt_t'(1);
			end
		end
	end

endmodule : sctr_tick

// File: rtl/sctr_ctrl.sv
`timescale 1ns/10ps
module sctr_ctrl (
	input wire logic clock_in, // 20 MHz clock, also the memory clock
	input wire logic srst_in, // sync reset, active high
	input wire logic ce_in, // clock enable, freezes all state
	input wire logic req_valid_in, // access request
	input wire logic req_write_in, // 1 write, 0 read
	input wire logic [sctr_pkg::BA_W-1:0] req_bank_in, // bank
	input wire logic [sctr_pkg::ROW_W-1:0] req_row_in, // row
	input wire logic [sctr_pkg::COL_W-1:0] req_col_in, // column
	input wire logic [sctr_pkg::DQ_W-1:0] req_wdata_in, // write word
	input wire logic hot_in, // above 85 C, async pin
	input wire logic self_refresh_in, // hold memory in self-refresh, async pin
	output logic req_ready_out, // request taken when valid and ready
	output logic [sctr_pkg::DQ_W-1:0] rdata_out, // read word
	output logic rdata_valid_out, // read word pulse
	output logic init_done_out, // wake-up sequence finished
	output logic sd_cke_out, // memory clock enable
	output logic sd_cs_n_out, // chip select, low active
	output logic sd_ras_n_out, // row strobe, low active
	output logic sd_cas_n_out, // column strobe, low active
	output logic sd_we_n_out, // write enable, low active
	output logic [sctr_pkg::BA_W-1:0] sd_ba_out, // bank address
	output logic [sctr_pkg::ADDR_W-1:0] sd_addr_out, // address
	output logic sd_dqm_out, // data mask
	input wire logic [sctr_pkg::DQ_W-1:0] sd_dq_in, // data pins in
	output logic [sctr_pkg::DQ_W-1:0] sd_dq_out, // data pins out
	output logic sd_dq_oe_n_out // data drive enable, low drives
);

	typedef enum {
		ST_BOOT, ST_PWR, ST_WAKE, ST_IDLE, ST_RW, ST_PRE, ST_BUSY, ST_SELF
	} sctr_state_t;

	sctr_state_t state_q;
	logic [3:0] cmd_q;
	logic cke_q;
	logic [sctr_pkg::BA_W-1:0] ba_q;
	logic [sctr_pkg::ADDR_W-1:0] addr_q;
	logic [sctr_pkg::DQ_W-1:0] dq_q;
	logic oe_n_q;
	logic ready_q;
	logic init_done_q;
	logic wr_q;
	logic [sctr_pkg::COL_W-1:0] col_q;
	sctr_pkg::sctr_cnt_t wait_q;
	logic [1:0] wake_cnt_q;
	logic restart_q;
	logic due_q;
	logic lapse_q;
	logic tick;
	logic [sctr_pkg::RD_CAP-1:0] rd_pipe_q;
	logic [sctr_pkg::DQ_W-1:0] rdata_q;
	logic rvalid_q;
	logic hot_s;
	logic sr_s;
	logic wait_done;

	// wait value that lets the next command go n cycles later
	function automatic sctr_pkg::sctr_cnt_t hold(input int n);
		return sctr_pkg::sctr_cnt_t'(n - 1);
	endfunction : hold

	// ----------------------------------------------------------------
	// pin synchronisers: change taken when stages two and three agree
	// ----------------------------------------------------------------
	logic [1:0] pin_raw;
	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic [1:0] s3_q;
	logic [1:0] filt_q;
	assign pin_raw = {hot_in, self_refresh_in};
	generate
		for (genvar i = 0; i < 2; i++) begin : g_sync
			always_ff @(posedge clock_in) begin
				if (srst_in) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					filt_q[i] <= 1'b0;
				end else if (ce_in) begin
					s1_q[i] <= pin_raw[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						filt_q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate
	assign hot_s = filt_q[1];
	assign sr_s = filt_q[0];

	// ----------------------------------------------------------------
	// refresh interval and flags
	// ----------------------------------------------------------------
	sctr_tick u_tick (
		.clock_in(clock_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.restart_in(restart_q),
		.period_in(hot_s ? sctr_pkg::sctr_cnt_t'(sctr_pkg::REF_INT_HOT_CYC) :
			sctr_pkg::sctr_cnt_t'(sctr_pkg::REF_INT_CYC)),
		.tick_out(tick)
	);

	// a tick in the same cycle as a refresh keeps the flag set
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			due_q <= 1'b0;
			lapse_q <= 1'b0;
		end else if (ce_in) begin
			if (tick && init_done_q && cke_q) begin
				due_q <= 1'b1;
				if (due_q) begin
					lapse_q <= 1'b1;
				end
			end else if (cmd_q == sctr_pkg::CMD_REF) begin
				due_q <= 1'b0;
				lapse_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	assign wait_done = (wait_q == '0);

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			state_q <= ST_BOOT;
			cmd_q <= sctr_pkg::CMD_NOP;
			cke_q <= 1'b1;
			ba_q <= '0;
			addr_q <= '0;
			dq_q <= '0;
			oe_n_q <= 1'b1;
			ready_q <= 1'b0;
			init_done_q <= 1'b0;
			wr_q <= 1'b0;
			col_q <= '0;
			wait_q <= '0;
			wake_cnt_q <= '0;
			restart_q <= 1'b0;
		end else if (ce_in) begin
			cmd_q <= sctr_pkg::CMD_NOP;
			oe_n_q <= 1'b1;
			ready_q <= 1'b0;
			restart_q <= 1'b0;
			if (!wait_done) begin
				wait_q <= wait_q - sctr_pkg::sctr_cnt_t'(1);
			end
			case (state_q)
				ST_BOOT: begin
					wait_q <= hold(sctr_pkg::PWR_CYC);
					state_q <= ST_PWR;
				end
				ST_PWR: if (wait_done) begin
					cmd_q <= sctr_pkg::CMD_PRE;
					addr_q <= '0;
					addr_q[sctr_pkg::AP_BIT] <= 1'b1;
					wait_q <= hold(sctr_pkg::PRE_WAIT);
					wake_cnt_q <= '0;
					state_q <= ST_WAKE;
				end
				ST_WAKE: if (wait_done) begin
					if (wake_cnt_q < 2'(sctr_pkg::WAKE_REFS)) begin
						cmd_q <= sctr_pkg::CMD_REF;
						wait_q <= hold(sctr_pkg::RC_CYC);
						wake_cnt_q <= wake_cnt_q + 2'(1);
					end else if (init_done_q) begin
						state_q <= ST_IDLE;
					end else begin
						cmd_q <= sctr_pkg::CMD_MRS;
						addr_q <= sctr_pkg::MODE_WORD;
						wait_q <= hold(sctr_pkg::MRD_CYC);
						init_done_q <= 1'b1;
						restart_q <= 1'b1;
						state_q <= ST_BUSY;
					end
				end
				ST_IDLE: if (wait_done) begin
					if (req_valid_in && ready_q) begin
						cmd_q <= sctr_pkg::CMD_ACT;
						ba_q <= req_bank_in;
						addr_q <= req_row_in;
						wr_q <= req_write_in;
						col_q <= req_col_in;
						dq_q <= req_wdata_in;
						wait_q <= hold(sctr_pkg::RCD_CYC);
						state_q <= ST_RW;
					end else if (lapse_q) begin
						wake_cnt_q <= '0;
						state_q <= ST_WAKE;
					end else if (due_q) begin
						cmd_q <= sctr_pkg::CMD_REF;
						wait_q <= hold(sctr_pkg::RC_CYC);
						state_q <= ST_BUSY;
					end else if (sr_s) begin
						cmd_q <= sctr_pkg::CMD_REF;
						cke_q <= 1'b0;
						state_q <= ST_SELF;
					end else begin
						ready_q <= 1'b1;
					end
				end
				ST_RW: if (wait_done && (!wr_q || rd_pipe_q == '0)) begin
					addr_q <= '0;
					addr_q[sctr_pkg::COL_W-1:0] <= col_q;
					// address bit for auto-precharge stays low
					if (wr_q) begin
						cmd_q <= sctr_pkg::CMD_WR;
						oe_n_q <= 1'b0;
						wait_q <= hold(sctr_pkg::WR_PRE_WAIT);
					end else begin
						cmd_q <= sctr_pkg::CMD_RD;
						wait_q <= hold(sctr_pkg::RD_PRE_WAIT);
					end
					state_q <= ST_PRE;
				end
				ST_PRE: if (wait_done) begin
					cmd_q <= sctr_pkg::CMD_PRE;
					addr_q <= '0;
					wait_q <= hold(sctr_pkg::PRE_WAIT);
					state_q <= ST_BUSY;
				end
				ST_BUSY: if (wait_done) begin
					state_q <= ST_IDLE;
				end
				ST_SELF: if (!sr_s) begin
					cke_q <= 1'b1;
					wait_q <= hold(sctr_pkg::SRX_WAIT);
					restart_q <= 1'b1;
					state_q <= ST_BUSY;
				end
				default: state_q <= ST_BOOT;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read capture, cas latency plus one cycle after the command leaves
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			rd_pipe_q <= '0;
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end else if (ce_in) begin
			rd_pipe_q <= {rd_pipe_q[sctr_pkg::RD_CAP-2:0], 1'b0};
			if (state_q == ST_RW && wait_done && !wr_q) begin
				rd_pipe_q[0] <= 1'b1;
			end
			rvalid_q <= rd_pipe_q[sctr_pkg::RD_CAP-1];
			if (rd_pipe_q[sctr_pkg::RD_CAP-1]) begin
				rdata_q <= sd_dq_in;
			end
		end
	end

	assign req_ready_out = ready_q;
	assign rdata_out = rdata_q;
	assign rdata_valid_out = rvalid_q;
	assign init_done_out = init_done_q;
	assign sd_cke_out = cke_q;
	assign {sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out} = cmd_q;
	assign sd_ba_out = ba_q;
	assign sd_addr_out = addr_q;
	assign sd_dqm_out = 1'b0;
	assign sd_dq_out = dq_q;
	assign sd_dq_oe_n_out = oe_n_q;

	// ----------------------------------------------------------------
	// spacing checks: cycles since each command other than read, and since clock enable rose, last showed on the pins
	// ----------------------------------------------------------------
	localparam int NS = 6;
	localparam int I_ACT = 0;
	localparam int I_PRE = 1;
	localparam int I_WR = 2;
	localparam int I_REF = 3;
	localparam int I_MRS = 4;
	localparam int I_SRX = 5;
	logic cke_d_q;
	logic [NS-1:0] seen;
	sctr_pkg::sctr_cnt_t since_q [NS];
	assign seen = {cke_q && !cke_d_q, cmd_q == sctr_pkg::CMD_MRS, cmd_q == sctr_pkg::CMD_REF,
		cmd_q == sctr_pkg::CMD_WR, cmd_q == sctr_pkg::CMD_PRE, cmd_q == sctr_pkg::CMD_ACT};
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			cke_d_q <= 1'b1;
		end else if (ce_in) begin
			cke_d_q <= cke_q;
		end
	end
	generate
		for (genvar i = 0; i < NS; i++) begin : g_since
			always_ff @(posedge clock_in) begin
				if (srst_in) begin
					since_q[i] <= '1;
				end else if (ce_in) begin
					if (seen[i]) begin
						since_q[i] <= sctr_pkg::sctr_cnt_t'(1);
					end else if (since_q[i] != '1) begin
						since_q[i] <= since_q[i] + sctr_pkg::sctr_cnt_t'(1);
					end
				end
			end
		end
	endgenerate

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (srst_in || !ce_in);

	sequence srx_idle_s;
		(cmd_q == sctr_pkg::CMD_NOP && cke_q) [*2];
	endsequence

	act_to_rw_a: assert property ((cmd_q == sctr_pkg::CMD_RD || cmd_q == sctr_pkg::CMD_WR)
		|-> since_q[I_ACT] >= sctr_pkg::RCD_CYC) else $error("access too soon after activate");
	act_to_pre_a: assert property ((cmd_q == sctr_pkg::CMD_PRE && init_done_q)
		|-> since_q[I_ACT] >= sctr_pkg::RAS_MIN_CYC && since_q[I_ACT] <= sctr_pkg::RAS_MAX_CYC)
		else $error("precharge outside row-active window");
	pre_to_act_a: assert property (cmd_q == sctr_pkg::CMD_ACT
		|-> since_q[I_PRE] >= sctr_pkg::RP_CYC) else $error("activate too soon after precharge");
	act_spacing_a: assert property (cmd_q == sctr_pkg::CMD_ACT
		|-> since_q[I_ACT] >= sctr_pkg::RC_CYC) else $error("activates closer than row cycle");
	bank_spacing_a: assert property (cmd_q == sctr_pkg::CMD_ACT
		|-> since_q[I_ACT] >= sctr_pkg::RRD_CYC) else $error("bank activates too close");
	wr_to_pre_a: assert property (cmd_q == sctr_pkg::CMD_PRE
		|-> since_q[I_WR] >= sctr_pkg::DPL_CYC) else $error("precharge too soon after write");
	wr_no_ap_a: assert property (cmd_q == sctr_pkg::CMD_WR
		|-> !addr_q[sctr_pkg::AP_BIT] && $past(cmd_q) != sctr_pkg::CMD_WR)
		else $error("write with auto-precharge issued");
	ref_spacing_a: assert property (cmd_q == sctr_pkg::CMD_REF
		|-> since_q[I_REF] >= sctr_pkg::RC_CYC) else $error("refreshes closer than row cycle");
	mode_wait_a: assert property ((cmd_q == sctr_pkg::CMD_ACT || cmd_q == sctr_pkg::CMD_REF)
		|-> since_q[I_MRS] >= sctr_pkg::MRD_CYC) else $error("command too soon after mode load");
	srx_act_a: assert property (cmd_q == sctr_pkg::CMD_ACT
		|-> since_q[I_SRX] >= sctr_pkg::XSR_CYC) else $error("activate too soon after exit");
	srx_clock_a: assert property ($rose(cke_q) |-> srx_idle_s)
		else $error("command during self-refresh exit");
	ref_lapse_a: assert property ((tick && due_q && init_done_q && cke_q)
		|=> lapse_q ##1 (lapse_q || state_q == ST_WAKE)) else $error("missed refresh not caught");
	boot_quiet_a: assert property ((state_q == ST_PWR && !wait_done)
		|-> cmd_q == sctr_pkg::CMD_NOP && !init_done_q) else $error("command during power-up");

endmodule : sctr_ctrl

// File: dv/sctr_mem_model.sv
`timescale 1ns/10ps
module sctr_mem_model (
	input wire logic clock_in, // memory clock
	input wire logic cke_in, // clock enable
	input wire logic [3:0] cmd_in, // cs_n ras_n cas_n we_n
	input wire logic [1:0] ba_in, // bank
	input wire logic [10:0] addr_in, // address
	input wire logic [31:0] dq_in, // write data
	input wire logic dq_oe_n_in, // low while controller drives
	input wire logic hot_in, // short refresh period
	output logic [31:0] dq_out, // read data
	output logic [15:0] viol_out, // spacing faults seen
	output logic [15:0] ref_cnt_out // refreshes seen
);
	int cyc = 0, viol = 0, refs = 0, refs_all = 0, idle = 0, lim, k;
	int any_act = -99999, last_ref = -99999, last_mrs = -99999, cke_rise = -99999;
	int act_t[4] = '{default: -99999};
	int pre_t[4] = '{default: -99999};
	int wr_t[4] = '{default: -99999};
	int rd_key = 0;
	logic [10:0] open_row[4];
	logic [31:0] mem[int];
	logic cke_q = 1'b1, rd_q = 1'b0, hot_q = 1'b0, gap_ok = 1'b0;
	assign viol_out = viol[15:0];
	assign ref_cnt_out = refs_all[15:0];
	initial dq_out = 32'h5A5A5A5A;

	task automatic need(input bit ok);
		if (!ok) viol++;
	endtask : need

	always @(posedge clock_in) begin
		cyc++;
		if (cke_in && !cke_q) cke_rise = cyc;
		// self-refresh keeps every row fresh
		if (!cke_in) last_ref = cyc;
		cke_q = cke_in;
		// one cycle of data, then a changing pattern once released
		dq_out <= rd_q ? (mem.exists(rd_key) ? mem[rd_key] : 32'h0BAD0000) : ~dq_out;
		rd_q <= 1'b0;
		k = {ba_in, open_row[ba_in], addr_in[7:0]};
		if (cke_in && (cmd_in[3] || cmd_in == sctr_pkg::CMD_NOP)) begin
			idle++;
			// a long pause means a fresh power-up sequence
			if (idle > 1000) begin
				gap_ok = 1'b0;
				refs = 0;
			end
		end else if (cke_in) begin
			idle = 0;
			need(cyc - cke_rise >= sctr_pkg::SRX_WAIT);
			need(cyc >= sctr_pkg::PWR_CYC);
			case (cmd_in)
				sctr_pkg::CMD_ACT: begin
					need(cyc - act_t[ba_in] >= sctr_pkg::RC_CYC);
					need(cyc - pre_t[ba_in] >= sctr_pkg::RP_CYC);
					need(cyc - any_act >= sctr_pkg::RRD_CYC);
					need(cyc - last_mrs >= sctr_pkg::MRD_CYC);
					need(cyc - cke_rise >= sctr_pkg::XSR_CYC);
					need(refs >= 2);
					act_t[ba_in] = cyc;
					any_act = cyc;
					open_row[ba_in] = addr_in;
				end
				sctr_pkg::CMD_RD: begin
					need(cyc - act_t[ba_in] >= sctr_pkg::RCD_CYC);
					rd_key <= k;
					rd_q <= 1'b1;
				end
				sctr_pkg::CMD_WR: begin
					need(cyc - act_t[ba_in] >= sctr_pkg::RCD_CYC);
					need(dq_oe_n_in === 1'b0);
					mem[k] = dq_in;
					wr_t[ba_in] = cyc;
					if (addr_in[sctr_pkg::AP_BIT]) pre_t[ba_in] = cyc + sctr_pkg::DPL_CYC;
				end
				sctr_pkg::CMD_PRE: for (int i = 0; i < 4; i++) begin
					if (addr_in[sctr_pkg::AP_BIT] || i == ba_in) begin
						need(cyc - act_t[i] >= sctr_pkg::RAS_MIN_CYC);
						need(cyc - wr_t[i] >= sctr_pkg::DPL_CYC);
						pre_t[i] = cyc;
					end
				end
				sctr_pkg::CMD_REF: begin
					lim = hot_q ? sctr_pkg::REF_INT_HOT_CYC : sctr_pkg::REF_INT_CYC;
					need(cyc - last_ref >= sctr_pkg::RC_CYC);
					need(cyc - last_mrs >= sctr_pkg::MRD_CYC);
					need(!gap_ok || cyc - last_ref <= lim + 16);
					last_ref = cyc;
					hot_q = hot_in;
					refs++;
					refs_all++;
				end
				sctr_pkg::CMD_MRS: begin
					last_mrs = cyc;
					gap_ok = 1'b1;
				end
				default: need(1'b0);
			endcase
		end
	end
endmodule : sctr_mem_model

// File: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	typedef struct packed {
		logic w;
		logic [1:0] b;
		logic [10:0] r;
		logic [7:0] c;
		logic [31:0] d;
	} sctr_row_t;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	logic ce_in = 1'b1;
	logic req_valid_in = 1'b0;
	logic req_write_in = 1'b0;
	logic [1:0] req_bank_in = 2'h0;
	logic [10:0] req_row_in = 11'h000;
	logic [7:0] req_col_in = 8'h00;
	logic [31:0] req_wdata_in = 32'h00000000;
	logic hot_in = 1'b0;
	logic self_refresh_in = 1'b0;
	logic req_ready_out, rdata_valid_out, init_done_out, sd_cke_out, sd_dqm_out;
	logic sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out, sd_dq_oe_n_out;
	logic [1:0] sd_ba_out;
	logic [10:0] sd_addr_out;
	logic [31:0] rdata_out, sd_dq_in, sd_dq_out;
	logic [15:0] viol, refs;
	int miscompares = 0;
	int num_checks = 0;
	int r0;
	sctr_row_t rows [10] = '{
		'{1'b1, 2'h0, 11'h000, 8'h00, 32'h01234567},
		'{1'b1, 2'h1, 11'h7FF, 8'hFF, 32'h89ABCDEF},
		'{1'b1, 2'h2, 11'h155, 8'h2A, 32'hFFFFFFFF},
		'{1'b1, 2'h3, 11'h2AA, 8'h55, 32'h00000000},
		'{1'b0, 2'h0, 11'h000, 8'h00, 32'h01234567},
		'{1'b0, 2'h1, 11'h7FF, 8'hFF, 32'h89ABCDEF},
		'{1'b1, 2'h1, 11'h7FF, 8'hFF, 32'h5A5AA5A5},
		'{1'b0, 2'h1, 11'h7FF, 8'hFF, 32'h5A5AA5A5},
		'{1'b0, 2'h2, 11'h155, 8'h2A, 32'hFFFFFFFF},
		'{1'b0, 2'h3, 11'h2AA, 8'h55, 32'h00000000}};

	always #25 clock_in = ~clock_in;

	sctr_ctrl uut (.clock_in, .srst_in, .ce_in, .req_valid_in, .req_write_in, .req_bank_in,
		.req_row_in, .req_col_in, .req_wdata_in, .hot_in, .self_refresh_in, .req_ready_out,
		.rdata_out, .rdata_valid_out, .init_done_out, .sd_cke_out, .sd_cs_n_out,
		.sd_ras_n_out, .sd_cas_n_out, .sd_we_n_out, .sd_ba_out, .sd_addr_out, .sd_dqm_out,
		.sd_dq_in, .sd_dq_out, .sd_dq_oe_n_out);

	sctr_mem_model mem (.clock_in, .cke_in(sd_cke_out),
		.cmd_in({sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out}), .ba_in(sd_ba_out),
		.addr_in(sd_addr_out), .dq_in(sd_dq_out), .dq_oe_n_in(sd_dq_oe_n_out), .hot_in,
		.dq_out(sd_dq_in), .viol_out(viol), .ref_cnt_out(refs));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		if (miscompares == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	task automatic wait_ready;
		int n;
		n = 0;
		while (req_ready_out !== 1'b1 && n < 3000) begin
			@(negedge clock_in);
			n++;
		end
		chk(req_ready_out, 1'b1);
	endtask : wait_ready

	// request stands from a falling edge; ready seen high there means the next rise takes it
	task automatic access(input sctr_row_t x);
		int n;
		n = 0;
		@(negedge clock_in);
		req_valid_in = 1'b1;
		req_write_in = x.w;
		req_bank_in = x.b;
		req_row_in = x.r;
		req_col_in = x.c;
		req_wdata_in = x.d;
		while (req_ready_out !== 1'b1 && n < 3000) begin
			@(negedge clock_in);
			n++;
		end
		for (int i = 1; i <= 5; i++) begin
			@(negedge clock_in);
			req_valid_in = 1'b0;
			if (!x.w) chk(rdata_valid_out, i == 5);
		end
		if (!x.w) chk(rdata_out, x.d);
	endtask : access

	task automatic reset_pins;
		chk({init_done_out, req_ready_out, sd_cke_out}, 3'h1);
		chk({sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out}, sctr_pkg::CMD_NOP);
	endtask : reset_pins

	initial begin
		repeat (20) @(negedge clock_in);
		srst_in = 1'b0;
		reset_pins;
		wait_ready;
		chk(init_done_out, 1'b1);
		chk(refs, 16'h0002);
		foreach (rows[i]) access(rows[i]);
		r0 = refs;
		repeat (2 * sctr_pkg::REF_INT_CYC + 40) @(negedge clock_in);
		chk(refs - r0 >= 2, 1'b1);
		hot_in = 1'b1;
		r0 = refs;
		repeat (sctr_pkg::REF_INT_CYC + 4 * sctr_pkg::REF_INT_HOT_CYC + 40) @(negedge clock_in);
		chk(refs - r0 >= 4, 1'b1);
		hot_in = 1'b0;
		self_refresh_in = 1'b1;
		repeat (40) @(negedge clock_in);
		chk(sd_cke_out, 1'b0);
		r0 = refs;
		repeat (60) @(negedge clock_in);
		chk(refs, r0[15:0]);
		self_refresh_in = 1'b0;
		wait_ready;
		chk(sd_cke_out, 1'b1);
		access(rows[9]);
		srst_in = 1'b1;
		repeat (3) @(negedge clock_in);
		srst_in = 1'b0;
		reset_pins;
		wait_ready;
		access(rows[7]);
		access(rows[8]);
		chk(viol, 16'h0000);
		final_report;
	end

	initial begin
		repeat (15000) @(posedge clock_in);
		miscompares++;
		final_report;
	end
endmodule : tb_top
